// ==== common/pgm_pkg.sv ====
// constants for the power-good supervisor: register offsets, fields, defaults, delays
// assumes a 250 MHz core clock and a byte-wide register port of the device
//
// Contract
// R1: status bit 7 reads 1 while reset comparator input is below 1 V.
// R2: two-bit delay field picks 20, 100, 200 or 400 ms release delay.
// R3: buck one good flag reads 1 only while its output is in range.
// R4: buck two good flag reads 1 only while its output is in range.
// R5: buck three good flag reads 1 only while its output is in range.
// R6: linreg one good flag reads 1 only while its output is in range.
// R7: linreg two good flag reads 1 only while its output is in range.
// R8: cleared mask bit 4..0 keeps that rail away from the power-good pin.
// R9: set mask bit pulls power-good low while that rail is bad.
// R10: joint mask bit 5 pulls power-good low when buck three and linreg one both bad.
// R11: under joint mask, one good rail of the pair keeps power-good released.
// R12: lockout restores mask and delay defaults; good flags stay live.
// R13: release only after conditions held for the full delay; faults restart it.
// R14: status bits read-only except delay; unused upper mask bits read zero.
package pgm_pkg;

    // ==================================================
    // register map
    localparam logic [7:0] RAIL_GOOD_STATUS_OFS = 8'h0b;
    localparam logic [7:0] RAIL_GOOD_MASK_OFS   = 8'h0c;

    // ==================================================
    // fields
    localparam int RST_BELOW_BIT  = 7;
    localparam int DELAY_LSB      = 5;
    localparam int JOINT_MASK_BIT = 5;
    localparam int BUCK_ONE_BIT   = 4;
    localparam int BUCK_TWO_BIT   = 3;
    localparam int BUCK_THREE_BIT = 2;
    localparam int LINREG_ONE_BIT = 1;
    localparam int LINREG_TWO_BIT = 0;
    localparam int RAIL_COUNT     = 5;

    // ==================================================
    // values loaded on lockout (variant dependent)
    localparam logic [1:0] DELAY_SEL_RESET = 2'h3;
    localparam logic [5:0] MASK_RESET      = 6'h1c;

    // ==================================================
    // timing
    localparam longint CLK_HZ      = 250000000;
    localparam longint DELAY0_MS   = 20;
    localparam longint DELAY1_MS   = 100;
    localparam longint DELAY2_MS   = 200;
    localparam longint DELAY3_MS   = 400;
    localparam int     CNT_W       = 27;
    localparam int     DELAY0_CYC  = int'(DELAY0_MS * CLK_HZ / 1000);
    localparam int     DELAY1_CYC  = int'(DELAY1_MS * CLK_HZ / 1000);
    localparam int     DELAY2_CYC  = int'(DELAY2_MS * CLK_HZ / 1000);
    localparam int     DELAY3_CYC  = int'(DELAY3_MS * CLK_HZ / 1000);

endpackage

// ==== hw/pgm_release_timer.sv ====
// release timer: output rises once its condition has held for limit cycles
// assumes condition and limit are synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pgm_release_timer #(
    parameter int CNT_W = 27
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             condOk,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  released
);

    initial begin
        if (CNT_W < 2) $error("pgm_release_timer: CNT_W too small");
    end

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_released;

    // ==================================================
    // next state
    always_comb begin
        next_count    = count;
        next_released = released;
        if (!condOk) begin
            next_count    = '0; // R13
            next_released = 1'b0; // R13
        end else if (!released) begin
            if (count >= limit - CNT_W'(1)) begin
                next_released = 1'b1; // R13
            end else begin
                next_count = count + CNT_W'(1);
            end
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            count    <= '0;
            released <= 1'b0;
        end else begin
            count    <= next_count;
            released <= next_released;
        end
    end

endmodule // pgm_release_timer
`default_nettype wire

// ==== hw/pgm_monitor.sv ====
// power-good supervisor: rail flag status, mask, release delay, open-drain power-good and reset out
// assumes rail flags, comparator and lockout come from analog and are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pgm_monitor #(
    parameter int         DELAY0_CYC = pgm_pkg::DELAY0_CYC,
    parameter int         DELAY1_CYC = pgm_pkg::DELAY1_CYC,
    parameter int         DELAY2_CYC = pgm_pkg::DELAY2_CYC,
    parameter int         DELAY3_CYC = pgm_pkg::DELAY3_CYC,
    parameter logic [1:0] DELAY_SEL_RESET = pgm_pkg::DELAY_SEL_RESET,
    parameter logic [5:0] MASK_RESET      = pgm_pkg::MASK_RESET
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       buckOneGood,
    input  wire logic       buckTwoGood,
    input  wire logic       buckThreeGood,
    input  wire logic       linregOneGood,
    input  wire logic       linregTwoGood,
    input  wire logic       resetCompBelow,
    input  wire logic       uvlo,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    output logic [7:0]      regRdData,
    output logic            railsOkOut,
    output logic            railsOkOe,
    output logic            resetOutN
);

    initial begin
        if (DELAY0_CYC < 1 || DELAY1_CYC < 1 || DELAY2_CYC < 1 || DELAY3_CYC < 1)
            $error("pgm_monitor: delay counts must be at least one cycle");
        if (DELAY3_CYC >= (1 << pgm_pkg::CNT_W))
            $error("pgm_monitor: delay count exceeds counter width");
    end

    // ==================================================
    // input synchronisers
    localparam int SYNC_W = 7;
    logic [SYNC_W-1:0] asyncIn;
    logic [SYNC_W-1:0] syncMeta;
    logic [SYNC_W-1:0] syncOut;

    assign asyncIn = {uvlo, resetCompBelow, buckOneGood, buckTwoGood,
                      buckThreeGood, linregOneGood, linregTwoGood};

    // reset value marks rails bad and lockout active, the safe side
    always_ff @(posedge clk) begin
        if (rst) begin
            syncMeta <= 7'h60;
            syncOut  <= 7'h60;
        end else begin
            syncMeta <= asyncIn;
            syncOut  <= syncMeta;
        end
    end

    logic [4:0] railGood;
    logic       compBelow;
    logic       lockout;

    assign railGood  = syncOut[4:0]; // R3 R4 R5 R6 R7
    assign compBelow = syncOut[5]; // R1
    assign lockout   = syncOut[6];

    // ==================================================
    // control registers
    logic [1:0] delaySel;
    logic [5:0] railSelect;
    logic [1:0] next_delaySel;
    logic [5:0] next_railSelect;

    always_comb begin
        next_delaySel   = delaySel;
        next_railSelect = railSelect;
        if (lockout) begin
            next_delaySel   = DELAY_SEL_RESET; // R12
            next_railSelect = MASK_RESET; // R12
        end else if (regWrEn) begin
            if (regAddr == pgm_pkg::RAIL_GOOD_STATUS_OFS) begin
                next_delaySel = regWrData[pgm_pkg::DELAY_LSB +: 2]; // R14
            end else if (regAddr == pgm_pkg::RAIL_GOOD_MASK_OFS) begin
                next_railSelect = regWrData[5:0]; // R14
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            delaySel   <= DELAY_SEL_RESET;
            railSelect <= MASK_RESET;
        end else begin
            delaySel   <= next_delaySel;
            railSelect <= next_railSelect;
        end
    end

    // ==================================================
    // fault evaluation
    logic railFault;
    logic jointFault;
    logic railsOkCond;
    logic resetOkCond;

    // only selected rails count against the pin
    assign railFault  = |(railSelect[4:0] & ~railGood); // R8 R9
    // joint term fires only when both rails of the pair are bad
    assign jointFault = railSelect[pgm_pkg::JOINT_MASK_BIT]
                        & ~railGood[pgm_pkg::BUCK_THREE_BIT]
                        & ~railGood[pgm_pkg::LINREG_ONE_BIT]; // R10 R11
    assign railsOkCond = ~railFault & ~jointFault & ~lockout;
    assign resetOkCond = ~compBelow & ~lockout;

    // ==================================================
    // release delay
    logic [pgm_pkg::CNT_W-1:0] delayLimit;

    always_comb begin
        case (delaySel)
            2'h0: delayLimit = pgm_pkg::CNT_W'(DELAY0_CYC); // R2
            2'h1: delayLimit = pgm_pkg::CNT_W'(DELAY1_CYC); // R2
            2'h2: delayLimit = pgm_pkg::CNT_W'(DELAY2_CYC); // R2
            default: delayLimit = pgm_pkg::CNT_W'(DELAY3_CYC); // R2
        endcase
    end

    logic railsReleased;
    logic resetReleased;

    pgm_release_timer #(
        .CNT_W (pgm_pkg::CNT_W)
    ) u_rails_timer (
        .clk      (clk),
        .rst      (rst),
        .condOk   (railsOkCond),
        .limit    (delayLimit),
        .released (railsReleased)
    );

    pgm_release_timer #(
        .CNT_W (pgm_pkg::CNT_W)
    ) u_reset_timer (
        .clk      (clk),
        .rst      (rst),
        .condOk   (resetOkCond),
        .limit    (delayLimit),
        .released (resetReleased)
    );

    // ==================================================
    // outputs: open drain pin only ever pulls low
    logic next_railsOkOe;
    logic next_resetOutN;
    logic [7:0] next_regRdData;

    always_comb begin
        next_railsOkOe = ~railsReleased; // R9 R13
        next_resetOutN = resetReleased; // R13
        next_regRdData = 8'h00;
        if (regAddr == pgm_pkg::RAIL_GOOD_STATUS_OFS) begin
            next_regRdData = {compBelow, delaySel, railGood}; // R1 R3 R4 R5 R6 R7
        end else if (regAddr == pgm_pkg::RAIL_GOOD_MASK_OFS) begin
            next_regRdData = {2'h0, railSelect}; // R14
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            railsOkOe <= 1'b1;
            resetOutN <= 1'b0;
            regRdData <= 8'h00;
        end else begin
            railsOkOe <= next_railsOkOe;
            resetOutN <= next_resetOutN;
            regRdData <= next_regRdData;
        end
    end

    assign railsOkOut = 1'b0;

endmodule // pgm_monitor
`default_nettype wire

// ==== sim/pgm_monitor_sva.sv ====
// checker: port relations of pgm_monitor
// assumes sync active-high rst on clk
`timescale 1ns/1ns
`default_nettype none
module pgm_monitor_sva #(parameter int DELAY0_CYC = 5) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       buckOneGood,
    input wire logic       buckTwoGood,
    input wire logic       buckThreeGood,
    input wire logic       linregOneGood,
    input wire logic       linregTwoGood,
    input wire logic       resetCompBelow,
    input wire logic       uvlo,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       railsOkOut,
    input wire logic       railsOkOe,
    input wire logic       resetOutN
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire logic [5:0] live = {resetCompBelow, buckOneGood, buckTwoGood, buckThreeGood, linregOneGood, linregTwoGood};
// ====
// relations; five cycles covers the synchroniser and read register
chk_drive_zero: assert property (railsOkOut == 1'b0)
    else $error("pin drive not low");
chk_unmapped_zero: assert property (regAddr != 8'h0b && regAddr != 8'h0c |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
chk_status_live: assert property (($stable(live) && regAddr == 8'h0b)[*5] |-> {regRdData[7], regRdData[4:0]} == live)
    else $error("status flags stale");
chk_delay_write: assert property ((!uvlo)[*3] ##1 (regWrEn && regAddr == 8'h0b) ##1 regAddr == 8'h0b
    |=> regRdData[6:5] == $past(regWrData[6:5], 2))
    else $error("delay field not written");
chk_mask_write: assert property ((!uvlo)[*3] ##1 (regWrEn && regAddr == 8'h0c) ##1 regAddr == 8'h0c
    |=> regRdData == {2'b00, $past(regWrData[5:0], 2)})
    else $error("mask not written");
chk_uvlo_hold: assert property (uvlo[*5] |-> railsOkOe && !resetOutN)
    else $error("outputs free in lockout");
// two sync stages, timer and output register: low is seen at the fifth sample
chk_comp_hold: assert property (resetCompBelow[*5] |-> !resetOutN)
    else $error("reset out free while below");
chk_fault_min: assert property ($rose(railsOkOe) |-> railsOkOe[*5])
    else $error("pin released too soon");
chk_reset_min: assert property ($fell(resetOutN) |-> (!resetOutN)[*5])
    else $error("reset released too soon");
endmodule // pgm_monitor_sva
`default_nettype wire

// ==== sim/pgm_host_model.sv ====
// host model: byte register port, pulled-up power-good pin
// assumes the design samples on posedge clk
`timescale 1ns/1ns
`default_nettype none
module pgm_host_model (
    input  wire logic       clk,
    output logic [7:0]      regAddr,
    output logic            regWrEn,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       railsOkOut,
    input  wire logic       railsOkOe,
    output logic            pinLevel
);
// pull-up wins whenever nobody drives
assign pinLevel = railsOkOe ? railsOkOut : 1'b1;
initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
end
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regWrData = ~d;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    d = regRdData;
endtask
endmodule // pgm_host_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// testbench: register, flag, delay, mask and lockout tests
// assumes shortened delays of 5, 10, 20, 40 cycles
`timescale 1ns/1ns
`default_nettype none
bind pgm_monitor pgm_monitor_sva #(.DELAY0_CYC(DELAY0_CYC)) chk (.clk, .rst, .buckOneGood, .buckTwoGood,
    .buckThreeGood, .linregOneGood, .linregTwoGood, .resetCompBelow, .uvlo, .regAddr, .regWrEn,
    .regWrData, .regRdData, .railsOkOut, .railsOkOe, .resetOutN);
module tb_top;
localparam int DLY [4] = '{5, 10, 20, 40};
logic       clk = 1'b0;
logic       rst = 1'b1;
logic [4:0] rails = 5'h00;
logic       below = 1'b1;
logic       uvlo = 1'b0;
logic [7:0] regAddr, regWrData, regRdData, rdVal;
logic       regWrEn, railsOkOut, railsOkOe, resetOutN, pin;
logic [13:0] mtab [7] = '{{8'h00, 5'h00, 1'b1}, {8'h10, 5'h0f, 1'b0}, {8'h20, 5'h1b, 1'b1},
    {8'h20, 5'h1d, 1'b1}, {8'h20, 5'h19, 1'b0}, {8'h01, 5'h1e, 1'b0}, {8'h1c, 5'h1f, 1'b1}};
int failCount = 0;
int totalChecks = 0;
int n;
always #2 clk = ~clk;
pgm_monitor #(.DELAY0_CYC(DLY[0]), .DELAY1_CYC(DLY[1]), .DELAY2_CYC(DLY[2]), .DELAY3_CYC(DLY[3])) DUT (
    .clk, .rst, .buckOneGood(rails[4]), .buckTwoGood(rails[3]), .buckThreeGood(rails[2]),
    .linregOneGood(rails[1]), .linregTwoGood(rails[0]), .resetCompBelow(below), .uvlo,
    .regAddr, .regWrEn, .regWrData, .regRdData, .railsOkOut, .railsOkOe, .resetOutN);
pgm_host_model host (.clk, .regAddr, .regWrEn, .regWrData, .regRdData, .railsOkOut, .railsOkOe, .pinLevel(pin));
// ====
// compare and closing tasks
task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
        failCount++;
        $display("ERROR %s exp %h got %h", nm, e, g);
    end
endtask
task automatic chk1(input string nm, input logic e, input logic g);
    totalChecks++;
    if (g !== e) begin
        failCount++;
        $display("ERROR %s exp %b got %b", nm, e, g);
    end
endtask
task automatic rdChk(input string nm, input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdVal);
    chk8(nm, e, rdVal);
endtask
task automatic reportAndStop();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
// ====
// tests
initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rdChk("status", 8'h0b, 8'he0);
    rdChk("mask", 8'h0c, 8'h1c);
    rdChk("unmapped", 8'h0d, 8'h00);
    below = 1'b0;
    for (int i = 0; i < 5; i++) begin
        rails = 5'h01 << i;
        repeat (4) @(negedge clk);
        rdChk("flags", 8'h0b, {3'h3, 5'(5'h01 << i)});
    end
    host.wr(8'h0b, 8'h9f);
    rdChk("ro bits", 8'h0b, 8'h10);
    $display("test registers done");
    host.wr(8'h0c, 8'h1f);
    for (int s = 0; s < 4; s++) begin
        host.wr(8'h0b, 8'(s << 5));
        rails = 5'h00;
        repeat (4) @(negedge clk);
        chk1("fault", 1'b0, pin);
        rails = 5'h1f;
        repeat (3) @(negedge clk);
        rails = 5'h0f;
        @(negedge clk);
        rails = 5'h1f;
        // a short dip must restart the whole count
        n = 0;
        while (pin !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk1("delay", 1'b1, n >= DLY[s] && n <= DLY[s] + 5);
    end
    chk1("reset out", 1'b1, resetOutN);
    below = 1'b1;
    repeat (5) @(negedge clk);
    chk1("reset held", 1'b0, resetOutN);
    rdChk("below flag", 8'h0b, 8'hff);
    below = 1'b0;
    // reset output follows the same programmed delay, last set to 400 ms code
    n = 0;
    while (resetOutN !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
    end
    chk1("reset delay", 1'b1, n >= DLY[3] && n <= DLY[3] + 5);
    $display("test delays done");
    host.wr(8'h0b, 8'h00);
    for (int k = 0; k < 7; k++) begin
        host.wr(mtab[k][13:6] == 8'h1c ? 8'h0c : 8'h0c, mtab[k][13:6]);
        rails = mtab[k][5:1];
        repeat (20) @(negedge clk);
        chk1("masked pin", mtab[k][0], pin);
    end
    $display("test masks done");
    // mask away from its default so lockout has something to restore
    host.wr(8'h0c, 8'h03);
    uvlo = 1'b1;
    repeat (4) @(negedge clk);
    host.wr(8'h0c, 8'h3f);
    rdChk("lockout mask", 8'h0c, 8'h1c);
    rdChk("lockout status", 8'h0b, {3'h3, rails});
    chk1("lockout pin", 1'b0, pin);
    $display("test lockout done");
    reportAndStop();
end
initial begin
    #100000;
    failCount++;
    reportAndStop();
end
endmodule // tb_top
`default_nettype wire
